// file: hdl/iec_top.sv
// encoder counter top: apb registers, signed tick total, flags, interrupt
`include "iec_defines.svh"
`default_nettype none

module iec_top
(
  // clock and reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_SYS_RST,
  // apb slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // encoder pins, step on a and direction on b in step format
  input  wire logic        I_ENC_A,
  input  wire logic        I_ENC_B,
  // interrupt
  output logic             O_IRQ
);
  import iec_pkg::*;

  // decoder interface
  iec_step_t                      step;
  iec_mode_t                      mode;

  // control register
  logic [1:0]                     ctrl_q;
  logic [1:0]                     ctrl_d;
  logic                           clear_req;

  // tick total and flags
  logic signed [31:0]             count_q;
  logic signed [31:0]             count_d;
  logic                           dir_q;
  logic                           dir_d;
  logic                           wrap_q;
  logic                           wrap_d;
  logic                           at_max;
  logic                           at_min;
  logic                           wrap_evt;
  logic                           step_evt;

  // interrupt registers
  logic [`IEC_IRQ_WIDTH-1:0]      istat_q;
  logic [`IEC_IRQ_WIDTH-1:0]      istat_d;
  logic [`IEC_IRQ_WIDTH-1:0]      imask_q;
  logic [`IEC_IRQ_WIDTH-1:0]      imask_d;
  logic [`IEC_IRQ_WIDTH-1:0]      events;
  logic [`IEC_IRQ_WIDTH-1:0]      w1c;
  logic                           irq_q;

  // bus registers
  logic [31:0]                    prdata_q;
  logic                           pready_q;
  logic                           pslverr_q;

  // bus decode
  logic                           setup;
  logic                           access;
  logic                           wr_acc;
  logic                           rd_acc;
  logic                           sel_ctrl;
  logic                           sel_count;
  logic                           sel_status;
  logic                           sel_istat;
  logic                           sel_imask;
  logic                           hit;
  logic [31:0]                    rd_mux;
  logic                           count_read;

  // front end: synchronisers and edge decode
  iec_decode u_decode
  (
    .i_clk     (I_CORE_CLK),
    .i_rst     (I_SYS_RST),
    .i_mode    (mode),
    .i_phase_a (I_ENC_A),
    .i_phase_b (I_ENC_B),
    .o_step    (step)
  );

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------

  // pready is high only in the access cycle, so every access is two cycles
  assign setup  = I_PSEL & ~I_PENABLE;
  assign access = I_PSEL & I_PENABLE & pready_q;
  assign wr_acc = access & I_PWRITE;
  assign rd_acc = access & ~I_PWRITE;

  // full byte address compare, so misaligned addresses miss
  assign sel_ctrl   = (I_PADDR == `IEC_ADDR_CTRL);
  assign sel_count  = (I_PADDR == `IEC_ADDR_COUNT);
  assign sel_status = (I_PADDR == `IEC_ADDR_STATUS);
  assign sel_istat  = (I_PADDR == `IEC_ADDR_IRQ_STAT);
  assign sel_imask  = (I_PADDR == `IEC_ADDR_IRQ_MASK);
  assign hit        = sel_ctrl | sel_count | sel_status | sel_istat |
                      sel_imask;

  // read data, unused bits read as zero; only a read of the total has a side effect, it clears wrap
  assign rd_mux =
    sel_ctrl   ? {30'h0, ctrl_q} :
    sel_count  ? count_q :                                   // [R7]
    sel_status ? {30'h0, wrap_q, dir_q} :
    sel_istat  ? {29'h0, istat_q} :
    sel_imask  ? {29'h0, imask_q} :
                 32'h0;

  // a completed read of the total is what clears the wrap flag
  assign count_read = rd_acc & sel_count;

  // ------------------------------------------------------------------
  // control register
  // ------------------------------------------------------------------

  // mode and clear are plain software levels
  assign ctrl_d    = (wr_acc && sel_ctrl) ? I_PWDATA[1:0] : ctrl_q;
  assign mode      = ctrl_q[`IEC_CTRL_MODE_BIT] ? IEC_STEPDIR : IEC_QUAD;
  assign clear_req = ctrl_q[`IEC_CTRL_CLR_BIT];

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_SYS_RST)
      ctrl_q <= `IEC_CTRL_RESET;
    else
      ctrl_q <= ctrl_d;
  end

  // ------------------------------------------------------------------
  // tick total
  // ------------------------------------------------------------------

  // wrap is detected before the add so the 32-bit sum can simply roll
  assign at_max   = (count_q == `IEC_COUNT_MAX);
  assign at_min   = (count_q == `IEC_COUNT_MIN);
  assign step_evt = step.valid & ~clear_req;
  assign wrap_evt = step_evt &
                    ((step.up & at_max) | (~step.up & at_min));   // [R9]

  // clear dominates any step in the same cycle
  always_comb
  begin
    count_d = count_q;
    if (clear_req)
      count_d = `IEC_COUNT_RESET;                                  // [R5]
    else if (step.valid && step.up)
      count_d = count_q + 32'sh00000001;                           // [R1] [R6]
    else if (step.valid)
      count_d = count_q - 32'sh00000001;                           // [R4] [R6]
  end

  // direction follows each counted step and survives a clear
  assign dir_d = step_evt ? step.up : dir_q;                       // [R8]

  // a rollover in the same cycle as the read wins over the clear
  assign wrap_d = wrap_evt | (wrap_q & ~count_read);               // [R10]

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_SYS_RST)
    begin
      count_q <= `IEC_COUNT_RESET;
      dir_q   <= 1'b0;
      wrap_q  <= 1'b0;
    end
    else
    begin
      count_q <= count_d;
      dir_q   <= dir_d;
      wrap_q  <= wrap_d;
    end
  end

  // ------------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------------

  // events: any count step, a rollover, a refused double phase change
  assign events[`IEC_IRQ_STEP_BIT] = step_evt;
  assign events[`IEC_IRQ_WRAP_BIT] = wrap_evt;
  assign events[`IEC_IRQ_BAD_BIT]  = step.bad & ~clear_req;        // [R11]

  // write one to clear; a new event in the same cycle keeps its bit set
  assign w1c     = (wr_acc && sel_istat) ?
                   I_PWDATA[`IEC_IRQ_WIDTH-1:0] : `IEC_IRQ_RESET;
  assign istat_d = (istat_q & ~w1c) | events;
  assign imask_d = (wr_acc && sel_imask) ?
                   I_PWDATA[`IEC_IRQ_WIDTH-1:0] : imask_q;

  // the output lags the status by one cycle to come from a flop
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_SYS_RST)
    begin
      istat_q <= `IEC_IRQ_RESET;
      imask_q <= `IEC_IRQ_RESET;
      irq_q   <= 1'b0;
    end
    else
    begin
      istat_q <= istat_d;
      imask_q <= imask_d;
      irq_q   <= |(istat_q & imask_q);
    end
  end

  // ------------------------------------------------------------------
  // apb answer
  // ------------------------------------------------------------------

  // read data is captured in setup, so the access cycle sees a stable word
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_SYS_RST)
    begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q  <= setup;
      prdata_q  <= (setup && !I_PWRITE) ? rd_mux : 32'h0;
      pslverr_q <= setup & ~hit;
    end
  end

  assign O_PRDATA  = prdata_q;
  assign O_PREADY  = pready_q;
  assign O_PSLVERR = pslverr_q;
  assign O_IRQ     = irq_q;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);

  // counts a clear held for several cycles, the total must stay zero
  sequence s_clear_held;
    clear_req [*3];
  endsequence

  chk_clear_zero: assert property (  // [R5]
    clear_req |=> (count_q == 32'sh0))
    else $error("total not zero after clear");

  chk_clear_holds: assert property (  // [R5]
    s_clear_held |-> (count_q == 32'sh0) && !wrap_evt)
    else $error("total moved while clear held");

  chk_count_up: assert property (  // [R1]
    (step.valid && step.up && !clear_req) |=>
      (count_q == $past(count_q) + 32'sh1))
    else $error("total did not increment");

  chk_count_down: assert property (  // [R4]
    (step.valid && !step.up && !clear_req) |=>
      (count_q == $past(count_q) - 32'sh1))
    else $error("total did not decrement");

  chk_idle_stable: assert property (  // [R7]
    (!step.valid && !clear_req) |=> $stable(count_q))
    else $error("total changed without a step");

  chk_read_value: assert property (  // [R7]
    (setup && !I_PWRITE && sel_count) |=> (O_PRDATA == $past(count_q)))
    else $error("read returned wrong total");

  chk_wrap_min: assert property (  // [R6]
    (step_evt && step.up && at_max) |=>
      (count_q == `IEC_COUNT_MIN) && wrap_q)
    else $error("maximum did not roll to minimum");

  chk_wrap_max: assert property (  // [R9]
    (step_evt && !step.up && at_min) |=>
      (count_q == `IEC_COUNT_MAX) && wrap_q)
    else $error("minimum did not roll to maximum");

  chk_wrap_read: assert property (  // [R10]
    (count_read && !wrap_evt) |=> !wrap_q)
    else $error("wrap flag survived a read");

  chk_wrap_sticky: assert property (  // [R10]
    (wrap_q && !count_read) |=> wrap_q)
    else $error("wrap flag dropped without a read");

  chk_dir_track: assert property (  // [R8]
    step_evt |=> (dir_q == $past(step.up)))
    else $error("direction flag does not follow step");

  chk_bad_ignored: assert property (  // [R11]
    (step.bad && !clear_req) |=> $stable(count_q))
    else $error("double phase change moved total");

  chk_irq_level: assert property (
    (|(istat_q & imask_q)) |=> O_IRQ)
    else $error("unmasked status did not raise interrupt");

  chk_apb_two_cycle: assert property (
    setup |=> O_PREADY ##1 !O_PREADY)
    else $error("access phase not exactly one cycle");

  // refused addresses answer with an error and zero data, nothing else does
  chk_err_unmapped: assert property (
    (setup && !hit) |=> (O_PSLVERR && (O_PRDATA == 32'h0)))
    else $error("unmapped address not refused");

  chk_err_mapped: assert property (
    (setup && hit) |=> !O_PSLVERR)
    else $error("mapped address answered with error");

  chk_ctrl_write: assert property (
    (wr_acc && sel_ctrl) |=> (ctrl_q == $past(I_PWDATA[1:0])))
    else $error("control write did not land");

  // the direction flag only follows counted steps, so a clear leaves it
  chk_clear_dir: assert property (  // [R5]
    clear_req |=> $stable(dir_q))
    else $error("direction flag moved during clear");

  // status bits: an event always sets, a written one clears the rest
  chk_event_sets: assert property (
    (|events) |=> ((istat_q & $past(events)) == $past(events)))
    else $error("event did not set its status bit");

  chk_w1c_clear: assert property (
    (wr_acc && sel_istat) |=>
      ((istat_q & $past(I_PWDATA[`IEC_IRQ_WIDTH-1:0]) &
        ~$past(events)) == `IEC_IRQ_RESET))
    else $error("written one did not clear status bit");

  chk_irq_low: assert property (
    !(|(istat_q & imask_q)) |=> !O_IRQ)
    else $error("interrupt high with no unmasked status");

  cov_wrap_up: cover property (step_evt && step.up && at_max);
  cov_wrap_down: cover property (step_evt && !step.up && at_min);
  cov_bad_edge: cover property (step.bad);
  cov_read_clear: cover property (count_read && wrap_q);
  cov_step_fmt: cover property (step_evt && (mode == IEC_STEPDIR));

endmodule

`default_nettype wire

// file: hdl/iec_defines.svh
// register map, field positions and reset values of the encoder counter
// Summary of operation
// R1 - In quadrature format the total moves on every edge of either phase.
// R2 - The encoder supplies two phases a quarter period apart, a Gray pair.
// R3 - In step format the total moves by one on each rising step edge only.
// R4 - The direction level seen at a step edge picks increment or decrement.
// R5 - While the clear request is set the total is forced to zero.
// R6 - The total is a two's-complement signed 32-bit value over its range.
// R7 - Reading the total returns counts since the last clear and changes none.
// R8 - A direction flag shows whether the latest count went up or down.
// R9 - The wrap flag sets when the total rolls between maximum and minimum.
// R10 - Reading the total clears the wrap flag until the next rollover.
// R11 - Inputs are double synchronised and double phase changes are ignored.
`ifndef IEC_DEFINES_SVH
`define IEC_DEFINES_SVH

// byte addresses on the register bus
`define IEC_ADDR_CTRL      8'h00
`define IEC_ADDR_COUNT     8'h04
`define IEC_ADDR_STATUS    8'h08
`define IEC_ADDR_IRQ_STAT  8'h0C
`define IEC_ADDR_IRQ_MASK  8'h10

// control fields
`define IEC_CTRL_MODE_BIT  0
`define IEC_CTRL_CLR_BIT   1
`define IEC_CTRL_RESET     2'h0

// status fields
`define IEC_STAT_DIR_BIT   0
`define IEC_STAT_WRAP_BIT  1

// interrupt event bits, same layout in status and mask
`define IEC_IRQ_STEP_BIT   0
`define IEC_IRQ_WRAP_BIT   1
`define IEC_IRQ_BAD_BIT    2
`define IEC_IRQ_WIDTH      3
`define IEC_IRQ_RESET      3'h0

// tick total limits
`define IEC_COUNT_MAX      32'h7FFFFFFF
`define IEC_COUNT_MIN      32'h80000000
`define IEC_COUNT_RESET    32'h00000000

`endif

// file: hdl/iec_pkg.sv
// types shared by the encoder counter modules
`default_nettype none

package iec_pkg;

  // input format of the encoder channel
  typedef enum logic
  {
    IEC_QUAD,
    IEC_STEPDIR
  } iec_mode_t;

  // one decoded movement from the front end
  typedef struct packed
  {
    logic valid;  // a count step happened this cycle
    logic up;     // step direction, high for increment
    logic bad;    // both quadrature phases changed together
  } iec_step_t;

endpackage

`default_nettype wire

// file: hdl/iec_decode.sv
// synchroniser and edge decoder for the encoder inputs
`default_nettype none

module iec_decode
(
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // format select
  input  wire iec_pkg::iec_mode_t i_mode,
  // raw encoder pins
  input  wire logic              i_phase_a,
  input  wire logic              i_phase_b,
  // decoded movement
  output iec_pkg::iec_step_t     o_step
);
  import iec_pkg::*;

  logic [1:0] meta_q;   // first stage, read only by the second
  logic [1:0] sync_q;   // second stage, safe to use
  logic [1:0] prev_q;   // last settled sample for edge detection
  logic       chg_a;
  logic       chg_b;
  logic       quad_up;
  logic       step_rise;

  // two-stage synchronisers plus history register [R11]
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      meta_q <= 2'h0;
      sync_q <= 2'h0;
      prev_q <= 2'h0;
    end
    else
    begin
      meta_q <= {i_phase_a, i_phase_b};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // gray walk 00-01-11-10 counts up [R2]
  assign chg_a     = sync_q[1] ^ prev_q[1];
  assign chg_b     = sync_q[0] ^ prev_q[0];
  assign quad_up   = prev_q[1] ^ sync_q[0];
  assign step_rise = sync_q[1] & ~prev_q[1];  // falling step ignored [R3]

  // one edge of either phase counts, a double change is refused [R1] [R11]
  always_comb
  begin
    o_step = '0;
    if (i_mode == IEC_QUAD)
    begin
      o_step.valid = chg_a ^ chg_b;              // [R1]
      o_step.up    = quad_up;
      o_step.bad   = chg_a & chg_b;              // [R11]
    end
    else
    begin
      o_step.valid = step_rise;                  // [R3]
      o_step.up    = sync_q[0];                  // [R4]
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_step_rise_only: assert property (  // [R3]
    (i_mode == IEC_STEPDIR && o_step.valid) |-> (sync_q[1] && !prev_q[1]))
    else $error("step counted without a rising step edge");

  chk_bad_no_count: assert property (  // [R11]
    o_step.bad |-> !o_step.valid)
    else $error("double phase change was counted");

endmodule

`default_nettype wire

// file: verif/iec_enc_model.sv
// behavioural shaft encoder that drives the counter's two pins
`default_nettype none

module iec_enc_model
(
  // clock
  input  wire logic i_clk,
  // encoder pins
  output var logic  o_enc_a,
  output var logic  o_enc_b
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] pos_q;  // position within one phase cycle

  // shaft at rest with both phases low, so release sees no step
  initial
  begin
    pos_q   = 2'h0;
    o_enc_a = 1'b0;
    o_enc_b = 1'b0;
  end

  // one quarter period; hold sets how slowly the shaft turns
  task automatic quad_move(input logic up, input int hold);
    @(posedge i_clk);
    pos_q = up ? pos_q + 2'h1 : pos_q - 2'h1;
    o_enc_a <= pos_q[1];
    o_enc_b <= pos_q[1] ^ pos_q[0];
    repeat (hold) @(posedge i_clk);
  endtask

  // faulty jump of half a period: both phases flip together
  task automatic quad_jump(input int hold);
    @(posedge i_clk);
    pos_q = pos_q + 2'h2;
    o_enc_a <= pos_q[1];
    o_enc_b <= pos_q[1] ^ pos_q[0];
    repeat (hold) @(posedge i_clk);
  endtask

  // direction settles before the step rises, low again afterwards
  task automatic step_pulse(input logic dir, input int hold);
    @(posedge i_clk);
    o_enc_b <= dir;
    repeat (hold) @(posedge i_clk);
    o_enc_a <= 1'b1;
    repeat (hold) @(posedge i_clk);
    o_enc_a <= 1'b0;
    repeat (hold) @(posedge i_clk);
  endtask
endmodule

`default_nettype wire

// file: verif/iec_top_tb.sv
// self-checking bench for the encoder counter top
`include "iec_defines.svh"
`default_nettype none

module iec_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        enc_a;
  logic        enc_b;
  logic        irq;
  logic [31:0] rdat;
  logic        rerr;
  int          err_count;
  int          samples_checked;
  int          cycles;

  iec_top DUT
  (
    .I_CORE_CLK (clk),
    .I_SYS_RST  (rst),
    .I_PSEL     (psel),
    .I_PENABLE  (penable),
    .I_PWRITE   (pwrite),
    .I_PADDR    (paddr),
    .I_PWDATA   (pwdata),
    .O_PRDATA   (prdata),
    .O_PREADY   (pready),
    .O_PSLVERR  (pslverr),
    .I_ENC_A    (enc_a),
    .I_ENC_B    (enc_b),
    .O_IRQ      (irq)
  );

  iec_enc_model enc
  (
    .i_clk   (clk),
    .o_enc_a (enc_a),
    .o_enc_b (enc_b)
  );

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // apb transfer; values read right after the edge are the pre-edge ones
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // the slave has no wait states, so the first access cycle answers
    chk(32'(n), 32'h1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
    chk({31'h0, rerr}, 32'h0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk({31'h0, rerr}, 32'h0);
  endtask

  // main sequence; reset was raised by the caller before it starts
  task automatic run_tests();
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // every register clears at reset; the slot past the map errors
    for (int i = 0; i < 5; i++)
      rd(8'(i * 4), 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk(rdat, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    $display("test reset_map done");
    // two full phase cycles up at a slow rate, three quarters down fast
    for (int i = 0; i < 8; i++)
      enc.quad_move(1'b1, 5);
    rd(`IEC_ADDR_COUNT, 32'h8);
    rd(`IEC_ADDR_STATUS, 32'h1);
    for (int i = 0; i < 3; i++)
      enc.quad_move(1'b0, 2);
    rd(`IEC_ADDR_COUNT, 32'h5);
    rd(`IEC_ADDR_COUNT, 32'h5);
    rd(`IEC_ADDR_STATUS, 32'h0);
    $display("test quadrature done");
    // double phase change: no count, event raised, masked in, cleared
    wr(`IEC_ADDR_IRQ_MASK, 32'h4);
    enc.quad_jump(5);
    rd(`IEC_ADDR_COUNT, 32'h5);
    rd(`IEC_ADDR_IRQ_STAT, 32'h5);
    chk({31'h0, irq}, 32'h1);
    wr(`IEC_ADDR_IRQ_STAT, 32'h5);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(`IEC_ADDR_IRQ_STAT, 32'h0);
    enc.quad_move(1'b1, 5);
    rd(`IEC_ADDR_COUNT, 32'h6);
    $display("test double_change done");
    // clear holds the total at zero even while the shaft turns
    wr(`IEC_ADDR_CTRL, 32'h2);
    rd(`IEC_ADDR_COUNT, 32'h0);
    for (int i = 0; i < 4; i++)
      enc.quad_move(1'b1, 3);
    rd(`IEC_ADDR_COUNT, 32'h0);
    wr(`IEC_ADDR_CTRL, 32'h0);
    for (int i = 0; i < 8; i++)
      enc.quad_move(1'b0, 3);
    rd(`IEC_ADDR_COUNT, 32'hFFFFFFF8);
    rd(`IEC_ADDR_STATUS, 32'h0);
    $display("test clear_signed done");
    // step and direction format
    wr(`IEC_ADDR_CTRL, 32'h1);
    for (int i = 0; i < 3; i++)
      enc.step_pulse(1'b1, 3);
    rd(`IEC_ADDR_COUNT, 32'hFFFFFFFB);
    rd(`IEC_ADDR_STATUS, 32'h1);
    for (int i = 0; i < 2; i++)
      enc.step_pulse(1'b0, 3);
    rd(`IEC_ADDR_COUNT, 32'hFFFFFFF9);
    rd(`IEC_ADDR_STATUS, 32'h0);
    rd(`IEC_ADDR_CTRL, 32'h1);
    // writes to the read-only total are dropped and reading keeps it
    wr(`IEC_ADDR_COUNT, 32'h00001234);
    rd(`IEC_ADDR_COUNT, 32'hFFFFFFF9);
    rd(`IEC_ADDR_IRQ_MASK, 32'h4);
    $display("test step_dir done");
  endtask

  // tests race the hang guard; whichever ends first reaches the verdict
  initial
  begin
    rst     <= 1'b1;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 8'h00;
    pwdata  <= 32'h0;
    err_count       = 0;
    samples_checked = 0;
    cycles          = 0;
    fork
      run_tests();
      begin
        // ceiling nearly twenty times the few hundred cycles the tests need
        while (cycles < 5000)
        begin
          @(posedge clk);
          cycles++;
        end
        err_count++;
        $display("ERROR t=%0t timeout cycles=%h limit=%h", $time,
                 cycles, 32'd5000);
      end
    join_any
    wrap_up();
  end
endmodule

`default_nettype wire
